/* File: tc8_chan.sv */
// Shared constants for the 8-bit timer, and one output-compare channel.
// Assumes one clock, a synchronous active-low reset and a one-cycle tick enable.
`timescale 1ns/1ps
`default_nettype none

package tc8_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0C;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_PORT = 8'h1C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTLA_WGM_LO = 0;
  localparam int CTLA_COMB_LO = 4;
  localparam int CTLA_COMA_LO = 6;
  localparam int CTLB_CS_LO = 0;
  localparam int CTLB_WGM2 = 3;
  localparam int CTLB_FORCE_B = 6;
  localparam int CTLB_FORCE_A = 7;
  localparam int FLG_OVF = 0;
  localparam int FLG_CMP_A = 1;
  localparam int FLG_CMP_B = 2;
  localparam int PORT_VAL_A = 0;
  localparam int PORT_VAL_B = 1;
  localparam int PORT_DIR_A = 2;
  localparam int PORT_DIR_B = 3;
  // ----------------------------------------------------------------
  // Values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_CMP = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
  localparam logic [9:0] PRE_RST = 10'h000;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

module tc8_chan
  import tc8_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic pwm_i,
  input wire logic fast_i,
  input wire logic toggle_ok_i,
  input wire logic load_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] cnt_i,
  input wire logic block_i,
  input wire logic force_i,
  input wire logic [1:0] com_i,
  input wire logic bottom_evt_i,
  input wire logic dir_up_i,
  output logic match_o,
  output logic [7:0] live_o,
  output logic [7:0] rd_o,
  output logic state_o
);
  logic [7:0] buf_q;
  logic [7:0] live_q;
  logic state_q;
  logic state_d;
  logic hit;

  // ----------------------------------------------------------------
  // Compare value and its buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      buf_q <= RST_BYTE;
    end else if (wr_i) begin
      buf_q <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      live_q <= RST_BYTE;
    end else if (wr_i && !pwm_i) begin
      live_q <= wdata_i;
    end else if (load_i && pwm_i) begin
      live_q <= buf_q;
    end
  end

  assign rd_o = pwm_i ? buf_q : live_q;
  assign live_o = live_q;
  assign match_o = (cnt_i == live_q) && !block_i;
  assign hit = (tick_i && match_o) || force_i;

  // ----------------------------------------------------------------
  // Output state; action read live from the mode bits
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (hit) begin
      unique case (com_i)
        COM_OFF: state_d = state_q;
        COM_TOGGLE: state_d = (!pwm_i || toggle_ok_i) ? !state_q : state_q;
        COM_CLEAR: state_d = pwm_i && !fast_i ? !dir_up_i : 1'b0;
        COM_SET: state_d = pwm_i && !fast_i ? dir_up_i : 1'b1;
      endcase
    end
    // Bottom wins over a match in the same tick so a maximum compare gives a steady level
    if (pwm_i && fast_i && bottom_evt_i && com_i[1]) begin
      state_d = (com_i == COM_CLEAR);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign state_o = state_q;
endmodule

`default_nettype wire

/* File: tc8_timer.sv */
// Top of the 8-bit timer: counter, two compare channels, flags, pins and register slave.
// Assumes an AXI4-Lite master on the one system clock; prescaler taps are local.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Each tick clears, increments or decrements counter
// - Clock select zero stops ticks, counter holds
// - Counter readable and writable at any time
// - Processor counter write beats counting
// - Three-bit mode split across control A, B
// - Overflow flag set per mode, requests interrupt
// - Counter compared continuously with both compare values
// - Match sets flag on following tick
// - Enabled flag interrupts; cleared by service, write-one
// - PWM buffers compare values, loaded at top
// - Access reaches buffer or live register
// - Force strobe updates output only, non-PWM
// - Counter write blocks matches for next tick
// - Output states kept across mode changes
// - Output mode bits unbuffered, act next match
// - Reset clears output states
// - Nonzero output mode overrides port pin value
// - Output mode zero leaves state unchanged
// - Step by one; clear zeroes counter
// - Top and bottom indications handle extremes
// - Top is maximum or compare A; bottom zero
// - Modes: 0 normal, 1/5 phase-correct, 2 match-clear, 3/7 fast
module tc8_timer
  import tc8_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ext_clock_pin_i,
  input wire logic overflow_ack_i,
  input wire logic compare_a_ack_i,
  input wire logic compare_b_ack_i,
  output logic overflow_irq_o,
  output logic compare_a_irq_o,
  output logic compare_b_irq_o,
  output logic compare_output_a_o,
  output logic compare_output_a_oe_o,
  output logic compare_output_b_o,
  output logic compare_output_b_oe_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_have_q;
  logic [7:0] aw_addr_q;
  logic w_have_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic wr_en;
  logic wr_mapped;
  logic [31:0] rd_mux;
  logic rd_mapped;
  logic [1:0] waveform_mode_lo_q;
  logic waveform_mode_bit2_q;
  logic [1:0] com_a_q;
  logic [1:0] com_b_q;
  logic [2:0] clock_select_field_q;
  logic [2:0] mask_q;
  logic [2:0] flags_q;
  logic [3:0] port_q;
  logic [7:0] counter_value_q;
  logic [7:0] cnt_d;
  logic dir_up_q;
  logic block_q;
  logic [9:0] presc_q;
  logic [2:0] ext_sync_q;
  logic timer_tick;
  logic [2:0] waveform_mode_field;
  logic mode_fast;
  logic mode_pc;
  logic mode_pwm;
  logic top_is_cmp;
  logic [7:0] top_val;
  logic at_top;
  logic at_bottom;
  logic ovf_evt;
  logic buf_load;
  logic bottom_evt;
  logic sel_ctrl_a;
  logic sel_ctrl_b;
  logic sel_count;
  logic sel_cmp_a;
  logic sel_cmp_b;
  logic sel_mask;
  logic sel_flags;
  logic sel_port;
  logic force_a;
  logic force_b;
  logic match_a;
  logic match_b;
  logic [7:0] live_a;
  logic [7:0] live_b;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic state_a;
  logic state_b;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready_o = !aw_have_q && !bvalid_q;
  assign s_axi_wready_o = !w_have_q && !bvalid_q;
  assign wr_go = aw_have_q && w_have_q && !bvalid_q;
  assign wr_en = wr_go && w_lane0_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= RST_BYTE;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      w_have_q <= 1'b0;
      w_data_q <= RST_BYTE;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata_i[7:0];
      w_lane0_q <= s_axi_wstrb_i[0];
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;

  assign sel_ctrl_a = wr_en && aw_addr_q == OFS_CTRL_A;
  assign sel_ctrl_b = wr_en && aw_addr_q == OFS_CTRL_B;
  assign sel_count = wr_en && aw_addr_q == OFS_COUNT;
  assign sel_cmp_a = wr_en && aw_addr_q == OFS_CMP_A;
  assign sel_cmp_b = wr_en && aw_addr_q == OFS_CMP_B;
  assign sel_mask = wr_en && aw_addr_q == OFS_MASK;
  assign sel_flags = wr_en && aw_addr_q == OFS_FLAGS;
  assign sel_port = wr_en && aw_addr_q == OFS_PORT;
  assign wr_mapped = aw_addr_q[1:0] == 2'h0 && aw_addr_q <= OFS_PORT;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr_i)
      OFS_CTRL_A: rd_mux[7:0] = {com_a_q, com_b_q, 2'h0, waveform_mode_lo_q};
      OFS_CTRL_B: rd_mux[7:0] = {4'h0, waveform_mode_bit2_q, clock_select_field_q};
      OFS_COUNT: rd_mux[7:0] = counter_value_q;
      OFS_CMP_A: rd_mux[7:0] = rd_a;
      OFS_CMP_B: rd_mux[7:0] = rd_b;
      OFS_MASK: rd_mux[2:0] = mask_q;
      OFS_FLAGS: rd_mux[2:0] = flags_q;
      OFS_PORT: rd_mux[3:0] = port_q;
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      waveform_mode_lo_q <= 2'h0;
      com_a_q <= COM_OFF;
      com_b_q <= COM_OFF;
    end else if (sel_ctrl_a) begin
      waveform_mode_lo_q <= w_data_q[CTLA_WGM_LO +: 2];
      com_a_q <= w_data_q[CTLA_COMA_LO +: 2];
      com_b_q <= w_data_q[CTLA_COMB_LO +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clock_select_field_q <= CS_STOP;
      waveform_mode_bit2_q <= 1'b0;
    end else if (sel_ctrl_b) begin
      clock_select_field_q <= w_data_q[CTLB_CS_LO +: 3];
      waveform_mode_bit2_q <= w_data_q[CTLB_WGM2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_q <= 3'h0;
      port_q <= 4'h0;
    end else begin
      if (sel_mask) begin
        mask_q <= w_data_q[2:0];
      end
      if (sel_port) begin
        port_q <= w_data_q[3:0];
      end
    end
  end

  // Strobes act at once and never store
  assign force_a = sel_ctrl_b && w_data_q[CTLB_FORCE_A] && !mode_pwm;
  assign force_b = sel_ctrl_b && w_data_q[CTLB_FORCE_B] && !mode_pwm;

  // ----------------------------------------------------------------
  // Tick generation
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      presc_q <= PRE_RST;
      ext_sync_q <= 3'h0;
    end else begin
      presc_q <= presc_q + 10'h001;
      ext_sync_q <= {ext_sync_q[1:0], ext_clock_pin_i};
    end
  end

  always_comb begin
    unique case (clock_select_field_q)
      CS_STOP: timer_tick = 1'b0;
      CS_DIV1: timer_tick = 1'b1;
      CS_DIV8: timer_tick = (presc_q & PRE_MASK_8) == PRE_MASK_8;
      CS_DIV64: timer_tick = (presc_q & PRE_MASK_64) == PRE_MASK_64;
      CS_DIV256: timer_tick = (presc_q & PRE_MASK_256) == PRE_MASK_256;
      CS_DIV1024: timer_tick = presc_q == PRE_MASK_1024;
      CS_EXT_FALL: timer_tick = ext_sync_q[2] && !ext_sync_q[1];
      CS_EXT_RISE: timer_tick = !ext_sync_q[2] && ext_sync_q[1];
    endcase
  end

  // ----------------------------------------------------------------
  // Counter unit
  // ----------------------------------------------------------------
  assign waveform_mode_field = {waveform_mode_bit2_q, waveform_mode_lo_q};
  assign mode_fast = waveform_mode_field == WGM_FAST_MAX
                  || waveform_mode_field == WGM_FAST_CMP;
  assign mode_pc = waveform_mode_field == WGM_PC_MAX || waveform_mode_field == WGM_PC_CMP;
  assign mode_pwm = mode_fast || mode_pc;
  assign top_is_cmp = waveform_mode_field == WGM_CTC || waveform_mode_field == WGM_FAST_CMP
                   || waveform_mode_field == WGM_PC_CMP;
  assign top_val = top_is_cmp ? live_a : CNT_MAX;
  assign at_top = counter_value_q == top_val;
  assign at_bottom = counter_value_q == CNT_BOTTOM;

  always_comb begin
    if (mode_pc) begin
      if (dir_up_q) begin
        cnt_d = at_top ? counter_value_q - 8'h01 : counter_value_q + 8'h01;
      end else begin
        cnt_d = at_bottom ? counter_value_q + 8'h01 : counter_value_q - 8'h01;
      end
    end else if (mode_fast || waveform_mode_field == WGM_CTC) begin
      cnt_d = at_top ? CNT_BOTTOM : counter_value_q + 8'h01;
    end else begin
      cnt_d = counter_value_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      counter_value_q <= RST_BYTE;
    end else if (sel_count) begin
      counter_value_q <= w_data_q;
    end else if (timer_tick) begin
      counter_value_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dir_up_q <= 1'b1;
    end else if (!mode_pc) begin
      dir_up_q <= 1'b1;
    end else if (timer_tick && dir_up_q && at_top) begin
      dir_up_q <= 1'b0;
    end else if (timer_tick && !dir_up_q && at_bottom) begin
      dir_up_q <= 1'b1;
    end
  end

  // Blocks matches until the end of the next tick, even when stopped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      block_q <= 1'b0;
    end else if (sel_count) begin
      block_q <= 1'b1;
    end else if (timer_tick) begin
      block_q <= 1'b0;
    end
  end

  assign ovf_evt = timer_tick && (mode_pc ? (!dir_up_q && at_bottom)
                 : mode_fast ? at_top : counter_value_q == CNT_MAX);
  assign buf_load = timer_tick && at_top && (mode_fast || dir_up_q);
  assign bottom_evt = timer_tick && at_top;

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  tc8_chan u_chan_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(timer_tick),
    .pwm_i(mode_pwm),
    .fast_i(mode_fast),
    .toggle_ok_i(waveform_mode_bit2_q),
    .load_i(buf_load),
    .wr_i(sel_cmp_a),
    .wdata_i(w_data_q),
    .cnt_i(counter_value_q),
    .block_i(block_q),
    .force_i(force_a),
    .com_i(com_a_q),
    .bottom_evt_i(bottom_evt),
    .dir_up_i(dir_up_q),
    .match_o(match_a),
    .live_o(live_a),
    .rd_o(rd_a),
    .state_o(state_a)
  );

  tc8_chan u_chan_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(timer_tick),
    .pwm_i(mode_pwm),
    .fast_i(mode_fast),
    .toggle_ok_i(1'b0),
    .load_i(buf_load),
    .wr_i(sel_cmp_b),
    .wdata_i(w_data_q),
    .cnt_i(counter_value_q),
    .block_i(block_q),
    .force_i(force_b),
    .com_i(com_b_q),
    .bottom_evt_i(bottom_evt),
    .dir_up_i(dir_up_q),
    .match_o(match_b),
    .live_o(live_b),
    .rd_o(rd_b),
    .state_o(state_b)
  );

  // ----------------------------------------------------------------
  // Flags and interrupt requests
  // ----------------------------------------------------------------
  assign flag_set[FLG_OVF] = ovf_evt;
  assign flag_set[FLG_CMP_A] = timer_tick && match_a;
  assign flag_set[FLG_CMP_B] = timer_tick && match_b;
  assign flag_clr = (sel_flags ? w_data_q[2:0] : 3'h0)
                  | {compare_b_ack_i, compare_a_ack_i, overflow_ack_i};

  // A new event in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
    end
  end

  assign overflow_irq_o = flags_q[FLG_OVF] && mask_q[FLG_OVF];
  assign compare_a_irq_o = flags_q[FLG_CMP_A] && mask_q[FLG_CMP_A];
  assign compare_b_irq_o = flags_q[FLG_CMP_B] && mask_q[FLG_CMP_B];

  // ----------------------------------------------------------------
  // Pin override
  // ----------------------------------------------------------------
  assign compare_output_a_o = (com_a_q != COM_OFF) ? state_a : port_q[PORT_VAL_A];
  assign compare_output_b_o = (com_b_q != COM_OFF) ? state_b : port_q[PORT_VAL_B];
  assign compare_output_a_oe_o = port_q[PORT_DIR_A];
  assign compare_output_b_oe_o = port_q[PORT_DIR_B];
endmodule

`default_nettype wire

/* File: tc8_cpu.sv */
// Processor-side master for the timer register bus, driven by bench calls.
// Assumes an AXI4-Lite slave on clk_i and a top module named tb.
`timescale 1ns/1ps
`default_nettype none
module tc8_cpu (
  input wire logic clk_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  logic [1:0] resp;
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
    wstrb_o = 4'hF;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= {24'h00_0000, d};
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (awready_i) awvalid_o <= 1'b0;
      if (wready_i) wvalid_o <= 1'b0;
    end while (!bvalid_i && n < 50);
    bready_o <= 1'b0;
    resp = bresp_i;
    if (n == 50) tb.timeout();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (arready_i) arvalid_o <= 1'b0;
    end while (!rvalid_i && n < 50);
    rready_o <= 1'b0;
    d = rdata_i;
    resp = rresp_i;
    if (n == 50) tb.timeout();
  endtask
endmodule
`default_nettype wire

/* File: tc8_timer_checker.sv */
// Port-level assertions for the 8-bit timer top.
// Assumes a bind onto tc8_timer.
`timescale 1ns/1ps
`default_nettype none
module tc8_timer_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic overflow_ack_i,
  input wire logic overflow_irq_o,
  input wire logic compare_output_a_o,
  input wire logic compare_output_a_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  a_reset_pins: assert property (disable iff (1'b0)
    !rst_n_i |=> !(compare_output_a_o || compare_output_a_oe_o || overflow_irq_o))
    else $error("no reset clear");
  a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid_o)
    else $error("no write resp");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_o)
    else $error("no read resp");
  a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("rdata moved");
  a_write_refuse: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken busy");
  a_read_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken busy");
  a_byte_data: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
    else $error("rdata over byte");
  a_dir_by_write: assert property (
    $past(rst_n_i) && $changed(compare_output_a_oe_o) |-> s_axi_bvalid_o)
    else $error("dir moved unwritten");
  a_irq_clear: assert property (
    $fell(overflow_irq_o) |-> $past(overflow_ack_i) || s_axi_bvalid_o || !$past(rst_n_i))
    else $error("irq dropped");
endmodule
bind tc8_timer tc8_timer_checker tc8_timer_checker_inst (.*);
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the 8-bit timer top.
// Assumes tc8_cpu as bus master; tick runs at the full clock rate.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tc8_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic overflow_ack_i = 1'b0;
  logic compare_a_ack_i = 1'b0;
  wire logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  wire logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  wire logic [3:0] s_axi_wstrb_i;
  wire logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  wire logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  wire logic overflow_irq_o, compare_a_irq_o, compare_output_a_o, compare_output_a_oe_o;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] v;
  tc8_timer tc8_timer_inst (.*, .ext_clock_pin_i(1'b0), .compare_b_ack_i(1'b0),
    .compare_b_irq_o(), .compare_output_b_o(), .compare_output_b_oe_o());
  tc8_cpu tc8_cpu_inst (.clk_i, .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
    .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
    .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
    .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
    .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
    .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));
  initial forever #4 clk_i = ~clk_i;
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    tc8_cpu_inst.wr(a, d);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    tc8_cpu_inst.rd(a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task timeout;
    fail_count++;
    report_and_stop();
  endtask
  task wait_ovf;
    for (int n = 0; overflow_irq_o !== 1'b1; n++) begin
      if (n == 400) timeout();
      @(posedge clk_i);
    end
  endtask
  task t_reset;
    for (int i = 0; i < 8; i++) rdc(8'(4 * i), 32'h0000_0000);
    chk(32'(compare_output_a_o), 32'h0000_0000);
    wr(8'h20, 8'h01);
    chk(32'(tc8_cpu_inst.resp), 32'(RESP_SLVERR));
    $display("reset test done");
  endtask
  task t_force;
    wr(OFS_CTRL_A, {COM_TOGGLE, 6'h00});
    wr(OFS_CTRL_B, 8'h80);
    wr(OFS_PORT, 8'h04);
    chk(32'(compare_output_a_o), 32'h0000_0001);
    wr(OFS_CTRL_B, 8'h80);
    chk(32'(compare_output_a_o), 32'h0000_0000);
    wr(OFS_CTRL_A, {COM_SET, 6'h00});
    chk(32'(compare_output_a_o), 32'h0000_0000);
    wr(OFS_CTRL_B, 8'h80);
    chk(32'(compare_output_a_o), 32'h0000_0001);
    wr(OFS_CTRL_A, 8'h00);
    chk({compare_output_a_o, compare_output_a_oe_o}, 32'h0000_0001);
    wr(OFS_CTRL_B, 8'h80);
    wr(OFS_CTRL_A, {COM_CLEAR, 6'h03});
    chk(32'(compare_output_a_o), 32'h0000_0001);
    wr(OFS_CTRL_B, 8'h80);
    chk(32'(compare_output_a_o), 32'h0000_0001);
    rdc(OFS_FLAGS, 32'h0000_0000);
    $display("force test done");
  endtask
  task t_block;
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_CMP_A, 8'h07);
    wr(OFS_COUNT, 8'h07);
    wr(OFS_CTRL_B, 8'(CS_DIV1));
    wr(OFS_CTRL_B, 8'(CS_STOP));
    rdc(OFS_FLAGS, 32'h0000_0000);
    rd(OFS_COUNT, v);
    rdc(OFS_COUNT, v);
    chk(32'(v > 32'h0000_0007 && v < 32'h0000_0010), 32'h0000_0001);
    $display("block test done");
  endtask
  task t_ovf;
    wr(OFS_MASK, 8'h03);
    wr(OFS_COUNT, 8'hF0);
    wr(OFS_CTRL_B, 8'(CS_DIV1));
    wait_ovf();
    repeat (10) @(posedge clk_i);
    chk({compare_a_irq_o, overflow_irq_o}, 32'h0000_0003);
    overflow_ack_i <= 1'b1;
    compare_a_ack_i <= 1'b1;
    @(posedge clk_i);
    overflow_ack_i <= 1'b0;
    compare_a_ack_i <= 1'b0;
    #1 chk({compare_a_irq_o, overflow_irq_o}, 32'h0000_0000);
    wait_ovf();
    wr(OFS_FLAGS, 8'h01);
    chk(32'(overflow_irq_o), 32'h0000_0000);
    $display("overflow test done");
  endtask
  task t_ctc;
    wr(OFS_CTRL_B, 8'(CS_STOP));
    wr(OFS_CTRL_A, 8'(WGM_CTC));
    wr(OFS_CMP_A, 8'h05);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CTRL_B, 8'(CS_DIV1));
    for (int i = 0; i < 6; i++) begin
      rd(OFS_COUNT, v);
      chk(32'(v <= 32'h0000_0005), 32'h0000_0001);
    end
    chk(32'(compare_a_irq_o), 32'h0000_0001);
    $display("match clear test done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_force();
    t_block();
    t_ovf();
    t_ctc();
    report_and_stop();
  end
endmodule
`default_nettype wire
